//--- brc_pkg.sv
// Constants and carrier types for the bridge abort and decode control block
package brc_pkg;
   // ****************************************************
   // Register map (byte addresses)
   // ****************************************************
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_SSTAT = 8'h0c;
   // ****************************************************
   // Control register fields
   // ****************************************************
   localparam int unsigned CTRL_W = 16;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'h002f;
   localparam int unsigned BIT_PAR = 0;
   localparam int unsigned BIT_SERR = 1;
   localparam int unsigned BIT_LEG = 2;
   localparam int unsigned BIT_VGA = 3;
   localparam int unsigned BIT_RSV = 4;
   localparam int unsigned BIT_MABT = 5;
   // ****************************************************
   // Interrupt status and secondary status fields
   // ****************************************************
   localparam int unsigned IRQ_W = 4;
   localparam logic [3:0] IRQ_RST = 4'h0;
   localparam int unsigned IRQ_SERR = 0;
   localparam int unsigned IRQ_PAR = 1;
   localparam int unsigned IRQ_HABT = 2;
   localparam int unsigned IRQ_PABT = 3;
   localparam int unsigned SSTAT_DPD = 8;
   // ****************************************************
   // Legacy display ranges and constants
   // ****************************************************
   localparam logic [31:0] MEM_LO = 32'h000a_0000;
   localparam logic [31:0] MEM_HI = 32'h000b_ffff;
   localparam logic [31:0] IO1_LO = 32'h0000_03b0;
   localparam logic [31:0] IO1_HI = 32'h0000_03bb;
   localparam logic [31:0] IO2_LO = 32'h0000_03c0;
   localparam logic [31:0] IO2_HI = 32'h0000_03df;
   localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
   localparam int unsigned SYNC_STAGES = 2;
   // ****************************************************
   // Carrier structs
   // ****************************************************
   typedef struct packed {
      logic valid;
      logic is_io;
      logic from_hub;
      logic in_window;
      logic [31:0] addr;
   } brc_dec_req_s;
   typedef struct packed {
      logic claim_down;
      logic pass_up;
   } brc_dec_rsp_s;
   typedef struct packed {
      logic valid;
      logic is_read;
   } brc_habt_s;
   typedef struct packed {
      logic tgt_abort;
      logic trdy;
      logic discard;
      logic [31:0] rdata;
   } brc_pci_rsp_s;
   typedef struct packed {
      logic valid;
      logic tgt_abort;
   } brc_hub_cpl_s;
endpackage

//--- brc_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module brc_sync #(
   parameter int unsigned W = 1,
   parameter int unsigned STAGES = brc_pkg::SYNC_STAGES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [STAGES*W-1:0] s_r;
   logic [STAGES*W-1:0] s_nxt;

   if (STAGES < 2 || W < 1) begin : g_chk
      $error("brc_sync needs at least two stages and one bit");
   end

   always_comb begin
      s_nxt = {s_r[(STAGES-1)*W-1:0], d};
   end

   // Reset value of all ones keeps an idle active-low pin quiet
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r[STAGES*W-1 -: W];
endmodule

//--- brc_decode.sv
// Legacy display range decode for downstream claim and upstream pass
`timescale 1ns/10ps
module brc_decode (
   // Control
   input wire logic vga_en,
   // Request and answer
   input wire brc_pkg::brc_dec_req_s req,
   output brc_pkg::brc_dec_rsp_s rsp
);
   logic mem_hit;
   logic io_hit;
   logic leg_hit;

   always_comb begin
      mem_hit = (req.addr >= brc_pkg::MEM_LO) && (req.addr <= brc_pkg::MEM_HI);
      io_hit = ((req.addr >= brc_pkg::IO1_LO) && (req.addr <= brc_pkg::IO1_HI))
         || ((req.addr >= brc_pkg::IO2_LO) && (req.addr <= brc_pkg::IO2_HI));
      leg_hit = req.is_io ? io_hit : mem_hit;
      rsp.claim_down = req.valid && req.from_hub && (req.in_window || (vga_en && leg_hit));
      // legacy ranges go upstream when off
      rsp.pass_up = req.valid && !req.from_hub && !req.in_window && !(vga_en && leg_hit);
   end
endmodule

//--- brc_bridge_ctrl.sv
// Bridge control bits: abort handling, legacy decode, error forwarding
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module brc_bridge_ctrl (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [brc_pkg::ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Hub and PCI sides
   input wire brc_pkg::brc_habt_s hub_mabort,
   input wire logic pci_mabort,
   output brc_pkg::brc_pci_rsp_s pci_rsp,
   output brc_pkg::brc_hub_cpl_s hub_cpl,
   output logic serr_cycle,
   // Address decode
   input wire brc_pkg::brc_dec_req_s dec_req,
   output brc_pkg::brc_dec_rsp_s dec_rsp,
   // PCI error pins
   input wire logic serr_n,
   input wire logic par_err,
   output logic perr_n_o,
   output logic perr_oe_n,
   // Interrupt
   output logic irq
);
   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed {
      logic [brc_pkg::CTRL_W-1:0] ctrl;
      logic [brc_pkg::IRQ_W-1:0] stat;
      logic [brc_pkg::IRQ_W-1:0] mask;
      logic dpd;
      logic ah_sel;
      logic ah_wr;
      logic [brc_pkg::ADDR_W-1:0] ah_addr;
      logic [31:0] rdata;
      brc_pkg::brc_pci_rsp_s pci;
      brc_pkg::brc_hub_cpl_s cpl;
      brc_pkg::brc_dec_rsp_s dec;
      logic serr_cyc;
      logic serr_d;
      logic perr_drv;
   } brc_state_s;

   brc_state_s s_r;
   brc_state_s s_nxt;
   logic serr_sync;
   logic serr_fell;
   logic ah_take;
   logic [brc_pkg::IRQ_W-1:0] ev;
   logic [brc_pkg::IRQ_W-1:0] rd_clr;
   brc_pkg::brc_dec_rsp_s dec_c;

   // ****************************************************
   // Pin synchroniser and decoder
   // ****************************************************
   brc_sync #(
      .W(1),
      .STAGES(brc_pkg::SYNC_STAGES)
   ) u_serr_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(serr_n),
      .q(serr_sync)
   );

   brc_decode u_decode (
      .vga_en(s_r.ctrl[brc_pkg::BIT_VGA]),
      .req(dec_req),
      .rsp(dec_c)
   );

   // ****************************************************
   // Next-state logic
   // ****************************************************
   always_comb begin
      s_nxt = s_r;
      ah_take = hsel && htrans[1] && hready;
      serr_fell = s_r.serr_d && !serr_sync;
      s_nxt.serr_d = serr_sync;

      // Data phase write, masked to implemented bits
      if (s_r.ah_sel && s_r.ah_wr) begin
         unique case (s_r.ah_addr)
            brc_pkg::OFS_CTRL: begin
               // abort select and other bits written
               s_nxt.ctrl = hwdata[15:0] & brc_pkg::CTRL_WMASK;
            end
            brc_pkg::OFS_MASK: begin
               s_nxt.mask = hwdata[brc_pkg::IRQ_W-1:0];
            end
            brc_pkg::OFS_SSTAT: begin
               if (hwdata[brc_pkg::SSTAT_DPD]) begin
                  s_nxt.dpd = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Hub-side master abort answered on PCI
      s_nxt.pci.tgt_abort = 1'b0;
      s_nxt.pci.trdy = 1'b0;
      s_nxt.pci.discard = 1'b0;
      if (hub_mabort.valid) begin
         if (s_r.ctrl[brc_pkg::BIT_MABT]) begin
            s_nxt.pci.tgt_abort = 1'b1;
         end else begin
            // complete with all ones or drop data
            s_nxt.pci.trdy = 1'b1;
            s_nxt.pci.discard = !hub_mabort.is_read;
            s_nxt.pci.rdata = brc_pkg::ALL_ONES;
         end
      end

      // PCI master abort of a hub request
      s_nxt.cpl.valid = pci_mabort;
      s_nxt.cpl.tgt_abort = pci_mabort && s_r.ctrl[brc_pkg::BIT_MABT];

      s_nxt.dec = dec_c;

      s_nxt.serr_cyc = serr_fell && s_r.ctrl[brc_pkg::BIT_SERR];

      s_nxt.perr_drv = par_err && s_r.ctrl[brc_pkg::BIT_PAR];
      if (par_err && s_r.ctrl[brc_pkg::BIT_PAR]) begin
         s_nxt.dpd = 1'b1;
      end

      // Sticky events, set wins over clear
      ev = '0;
      ev[brc_pkg::IRQ_SERR] = s_nxt.serr_cyc;
      ev[brc_pkg::IRQ_PAR] = s_nxt.perr_drv;
      ev[brc_pkg::IRQ_HABT] = hub_mabort.valid;
      ev[brc_pkg::IRQ_PABT] = pci_mabort;
      s_nxt.stat = s_r.stat | ev;

      // Address phase: capture read data, read clears status
      rd_clr = '0;
      s_nxt.ah_sel = ah_take;
      if (ah_take) begin
         s_nxt.ah_wr = hwrite;
         s_nxt.ah_addr = haddr;
         if (!hwrite) begin
            s_nxt.rdata = '0;
            unique case (haddr)
               brc_pkg::OFS_CTRL: begin
                  s_nxt.rdata[15:0] = s_nxt.ctrl;
               end
               brc_pkg::OFS_STAT: begin
                  s_nxt.rdata[brc_pkg::IRQ_W-1:0] = s_nxt.stat;
                  rd_clr = s_r.stat;
               end
               brc_pkg::OFS_MASK: begin
                  s_nxt.rdata[brc_pkg::IRQ_W-1:0] = s_nxt.mask;
               end
               brc_pkg::OFS_SSTAT: begin
                  s_nxt.rdata[brc_pkg::SSTAT_DPD] = s_nxt.dpd;
               end
               default: begin
               end
            endcase
         end
      end
      s_nxt.stat = (s_r.stat & ~rd_clr) | ev;
   end

   // ****************************************************
   // State register
   // ****************************************************
   // control register clears on reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
         s_r.ctrl <= brc_pkg::CTRL_RST;
         s_r.stat <= brc_pkg::IRQ_RST;
         s_r.mask <= brc_pkg::IRQ_RST;
         s_r.serr_d <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign hrdata = s_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign pci_rsp = s_r.pci;
   assign hub_cpl = s_r.cpl;
   assign dec_rsp = s_r.dec;
   assign serr_cycle = s_r.serr_cyc;
   assign perr_n_o = 1'b0;
   assign perr_oe_n = !s_r.perr_drv;
   assign irq = |(s_r.stat & s_r.mask);

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence hub_abt_set_s;
      hub_mabort.valid && s_r.ctrl[brc_pkg::BIT_MABT];
   endsequence

   sequence hub_abt_clr_s;
      hub_mabort.valid && !s_r.ctrl[brc_pkg::BIT_MABT];
   endsequence

   sequence perr_pulse_s;
      !perr_oe_n ##1 perr_oe_n;
   endsequence

   a_hub_tgt_abort: assert property (
      hub_abt_set_s |=> pci_rsp.tgt_abort && !pci_rsp.trdy
   ) else $error("hub abort with select set did not target abort");

   a_hub_trdy_ones: assert property (
      hub_abt_clr_s |=> pci_rsp.trdy && !pci_rsp.tgt_abort
         && pci_rsp.rdata == brc_pkg::ALL_ONES
         && pci_rsp.discard == !$past(hub_mabort.is_read)
   ) else $error("hub abort with select clear did not complete");

   a_cpl_target: assert property (
      pci_mabort && s_r.ctrl[brc_pkg::BIT_MABT] |=> hub_cpl.valid && hub_cpl.tgt_abort
   ) else $error("pci abort did not return target abort packet");

   a_cpl_normal: assert property (
      pci_mabort && !s_r.ctrl[brc_pkg::BIT_MABT] |=> hub_cpl.valid && !hub_cpl.tgt_abort
   ) else $error("pci abort did not return normal completion");

   a_legacy_claim: assert property (
      dec_req.valid && dec_req.from_hub && s_r.ctrl[brc_pkg::BIT_VGA]
         && !dec_req.is_io && dec_req.addr >= brc_pkg::MEM_LO
         && dec_req.addr <= brc_pkg::MEM_HI
         |=> dec_rsp.claim_down && !dec_rsp.pass_up
   ) else $error("legacy memory not claimed downstream");

   a_legacy_up: assert property (
      dec_req.valid && !dec_req.from_hub && !dec_req.in_window
         && !s_r.ctrl[brc_pkg::BIT_VGA] |=> dec_rsp.pass_up && !dec_rsp.claim_down
   ) else $error("pci access not passed upstream");

   a_legacy_window: assert property (
      dec_req.valid && dec_req.from_hub && !dec_req.in_window
         && !s_r.ctrl[brc_pkg::BIT_VGA] |=> !dec_rsp.claim_down
   ) else $error("claimed outside window with forward off");

   a_serr_forward: assert property (
      s_r.serr_d && !serr_sync && s_r.ctrl[brc_pkg::BIT_SERR] |=> serr_cycle ##1 !serr_cycle
   ) else $error("serr assertion not forwarded as one pulse");

   a_serr_blocked: assert property (
      serr_cycle |-> $past(s_r.ctrl[brc_pkg::BIT_SERR]) && $past(serr_sync, 1) == 1'b0
   ) else $error("special cycle without enable or serr");

   a_perr_drive: assert property (
      par_err && s_r.ctrl[brc_pkg::BIT_PAR] ##1 !(par_err && s_r.ctrl[brc_pkg::BIT_PAR])
         |-> perr_pulse_s and s_r.dpd
   ) else $error("parity error not driven or flagged");

   a_perr_quiet: assert property (
      $rose(s_r.dpd) || !perr_oe_n |-> $past(par_err && s_r.ctrl[brc_pkg::BIT_PAR])
   ) else $error("parity response while disabled");

   a_reset_zero: assert property (
      @(posedge hclk) $rose(hresetn) |-> s_r.ctrl == brc_pkg::CTRL_RST
   ) else $error("control register not zero after reset");

   a_reserved_zero: assert property (
      s_r.ctrl[brc_pkg::BIT_RSV] == 1'b0 && s_r.ctrl[15:6] == '0
   ) else $error("reserved control bits set");

   a_stat_sticky: assert property (
      s_r.stat[brc_pkg::IRQ_HABT] && !(ah_take && !hwrite && haddr == brc_pkg::OFS_STAT)
         |=> s_r.stat[brc_pkg::IRQ_HABT]
   ) else $error("status bit lost without read");

   a_stat_clear: assert property (
      ah_take && !hwrite && haddr == brc_pkg::OFS_STAT && !hub_mabort.valid
         |=> !s_r.stat[brc_pkg::IRQ_HABT]
   ) else $error("status read did not clear");

   a_hub_idle: assert property (
      !hub_mabort.valid |=> !pci_rsp.tgt_abort && !pci_rsp.trdy && !pci_rsp.discard
   ) else $error("pci response without hub abort");

   a_cpl_idle: assert property (
      !pci_mabort |=> !hub_cpl.valid
   ) else $error("completion without pci abort");

   a_dec_idle: assert property (
      !dec_req.valid |=> dec_rsp.claim_down == 1'b0 && dec_rsp.pass_up == 1'b0
   ) else $error("decode answer without request");

   a_legacy_io: assert property (
      dec_req.valid && dec_req.from_hub && dec_req.is_io && s_r.ctrl[brc_pkg::BIT_VGA]
         && ((dec_req.addr >= brc_pkg::IO1_LO && dec_req.addr <= brc_pkg::IO1_HI)
         || (dec_req.addr >= brc_pkg::IO2_LO && dec_req.addr <= brc_pkg::IO2_HI))
         |=> dec_rsp.claim_down && !dec_rsp.pass_up
   ) else $error("legacy io not claimed downstream");

   a_serr_quiet: assert property (
      s_r.serr_d && !serr_sync && !s_r.ctrl[brc_pkg::BIT_SERR] |=> !serr_cycle
   ) else $error("special cycle sent while disabled");

   a_perr_off: assert property (
      par_err && !s_r.ctrl[brc_pkg::BIT_PAR] |=> perr_oe_n && !$rose(s_r.dpd)
   ) else $error("parity driven while disabled");
endmodule

//--- brc_far_model.sv
// Far-side model: hub controller and PCI agents that raise events
`timescale 1ns/10ps
module brc_far_model (
   // Clock
   input wire logic hclk,
   // Events and decode requests
   output brc_pkg::brc_habt_s hub_mabort,
   output logic pci_mabort,
   output brc_pkg::brc_dec_req_s dec_req,
   output logic serr_n,
   output logic par_err
);
   initial begin
      hub_mabort = '0;
      pci_mabort = 1'b0;
      dec_req = '0;
      serr_n = 1'b1;
      par_err = 1'b0;
   end
   task automatic hub_abort(input logic rd);
      @(posedge hclk);
      hub_mabort <= {1'b1, rd};
      @(posedge hclk);
      hub_mabort <= {1'b0, ~rd};
   endtask
   task automatic pci_abort();
      @(posedge hclk);
      pci_mabort <= 1'b1;
      @(posedge hclk);
      pci_mabort <= 1'b0;
   endtask
   task automatic parity();
      @(posedge hclk);
      par_err <= 1'b1;
      @(posedge hclk);
      par_err <= 1'b0;
   endtask
   // Idle request shows inverted fields, not stale ones
   task automatic decode(input logic hub, input logic io, input logic win,
                         input logic [31:0] a);
      @(posedge hclk);
      dec_req <= {1'b1, io, hub, win, a};
      @(posedge hclk);
      dec_req <= {1'b0, ~io, ~hub, ~win, ~a};
   endtask
   // Pulled-up line: released means high
   task automatic serr_level(input logic v);
      @(posedge hclk);
      serr_n <= v;
   endtask
endmodule

//--- tb_bridge_abort_decode_control.sv
// Self-checking bench for the bridge control block
`timescale 1ns/10ps
module tb_bridge_abort_decode_control;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [brc_pkg::ADDR_W-1:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = '0;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   brc_pkg::brc_habt_s hub_mabort;
   brc_pkg::brc_pci_rsp_s pci_rsp;
   brc_pkg::brc_hub_cpl_s hub_cpl;
   brc_pkg::brc_dec_req_s dec_req;
   brc_pkg::brc_dec_rsp_s dec_rsp;
   logic pci_mabort;
   logic serr_n;
   logic par_err;
   logic serr_cycle;
   logic perr_n_o;
   logic perr_oe_n;
   logic irq;
   int err_count = 0;
   int compares = 0;
   logic [31:0] rd;
   // Decode cases: {vga,hub,io,win,claim,pass} then address
   localparam logic [39:0] DTAB [16] = '{
      {8'h32, 32'h000a_0000}, {8'h32, 32'h000b_ffff}, {8'h30, 32'h000c_0000},
      {8'h3a, 32'h0000_03bb}, {8'h38, 32'h0000_03bc}, {8'h3a, 32'h0000_03c0},
      {8'h3a, 32'h0000_03df}, {8'h38, 32'h0000_03e0}, {8'h20, 32'h000a_0000},
      {8'h21, 32'h0009_ffff}, {8'h10, 32'h000a_0000}, {8'h16, 32'h000a_0000},
      {8'h01, 32'h000a_0000}, {8'h09, 32'h0000_03b0}, {8'h38, 32'h000a_0000},
      {8'h2c, 32'h0000_03c0}};
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   brc_bridge_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hub_mabort(hub_mabort),
      .pci_mabort(pci_mabort), .pci_rsp(pci_rsp), .hub_cpl(hub_cpl),
      .serr_cycle(serr_cycle), .dec_req(dec_req), .dec_rsp(dec_rsp), .serr_n(serr_n),
      .par_err(par_err), .perr_n_o(perr_n_o), .perr_oe_n(perr_oe_n), .irq(irq));
   brc_far_model fm (.hclk(hclk), .hub_mabort(hub_mabort), .pci_mabort(pci_mabort),
      .dec_req(dec_req), .serr_n(serr_n), .par_err(par_err));
   task automatic complete_run();
      if (err_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One single AHB-Lite transfer, waits on hready in both phases
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, rd);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
      ahb(1'b0, a, 32'h0, rd);
      chk(36'(rd), 36'(e), m);
      chk(36'(hresp), 36'h0, "hresp");
   endtask
   task automatic t_reset();
      chk(36'(pci_rsp), 36'h0, "pci_rsp reset");
      chk(36'(perr_oe_n), 36'h1, "perr reset");
      chk(36'(irq), 36'h0, "irq reset");
      chk(36'(hreadyout), 36'h1, "hreadyout");
      rchk(brc_pkg::OFS_CTRL, 32'h0, "ctrl reset");
      rchk(brc_pkg::OFS_STAT, 32'h0, "stat reset");
      rchk(brc_pkg::OFS_MASK, 32'h0, "mask reset");
      rchk(brc_pkg::OFS_SSTAT, 32'h0, "sstat reset");
      rchk(8'h10, 32'h0, "unmapped");
   endtask
   task automatic t_ctrl();
      wr(brc_pkg::OFS_CTRL, 32'hffff_ffff);
      rchk(brc_pkg::OFS_CTRL, 32'h0000_002f, "ctrl all");
      wr(brc_pkg::OFS_CTRL, 32'h0000_0010);
      rchk(brc_pkg::OFS_CTRL, 32'h0, "ctrl bit4");
   endtask
   task automatic t_abort();
      fm.hub_abort(1'b1);
      #1;
      chk(36'(pci_rsp), 36'h2_ffff_ffff, "hub abort read");
      @(posedge hclk);
      #1;
      chk(36'(pci_rsp[34:32]), 36'h0, "pulse length");
      fm.hub_abort(1'b0);
      #1;
      chk(36'(pci_rsp), 36'h3_ffff_ffff, "hub abort write");
      fm.pci_abort();
      #1;
      chk(36'(hub_cpl), 36'h2, "normal completion");
      wr(brc_pkg::OFS_CTRL, 32'h0000_0020);
      fm.hub_abort(1'b1);
      #1;
      chk(36'(pci_rsp[34:32]), 36'h4, "target abort");
      fm.pci_abort();
      #1;
      chk(36'(hub_cpl), 36'h3, "abort packet");
   endtask
   task automatic t_dec();
      logic [39:0] e;
      for (int i = 0; i < 16; i++) begin
         for (int l = 0; l < 2; l++) begin
            e = DTAB[i];
            wr(brc_pkg::OFS_CTRL, {28'h0, e[37], l[0], 2'h0});
            fm.decode(e[36], e[35], e[34], e[31:0]);
            #1;
            chk(36'(dec_rsp), 36'(e[33:32]), "decode");
         end
      end
   endtask
   task automatic t_serr();
      int n;
      for (int en = 0; en < 2; en++) begin
         wr(brc_pkg::OFS_CTRL, {30'h0, en[0], 1'b0});
         n = 0;
         fm.serr_level(1'b0);
         repeat (8) begin
            @(posedge hclk);
            #1;
            if (serr_cycle === 1'b1) n++;
         end
         fm.serr_level(1'b1);
         repeat (4) @(posedge hclk);
         chk(36'(n), 36'(en), "serr cycles");
      end
   endtask
   task automatic t_par();
      rchk(brc_pkg::OFS_STAT, 32'hd, "stat events");
      wr(brc_pkg::OFS_MASK, 32'h2);
      wr(brc_pkg::OFS_CTRL, 32'h1);
      fm.pci_abort();
      #1;
      chk(36'(irq), 36'h0, "masked irq");
      fm.parity();
      #1;
      chk(36'({perr_oe_n, perr_n_o}), 36'h0, "perr driven");
      chk(36'(irq), 36'h1, "irq");
      rchk(brc_pkg::OFS_STAT, 32'ha, "stat");
      @(posedge hclk);
      #1;
      chk(36'(irq), 36'h0, "irq cleared");
      rchk(brc_pkg::OFS_SSTAT, 32'h100, "dpd set");
      wr(brc_pkg::OFS_SSTAT, 32'h100);
      rchk(brc_pkg::OFS_SSTAT, 32'h0, "dpd clear");
      wr(brc_pkg::OFS_CTRL, 32'h0);
      fm.parity();
      #1;
      chk(36'(perr_oe_n), 36'h1, "perr quiet");
      rchk(brc_pkg::OFS_SSTAT, 32'h0, "dpd quiet");
      rchk(brc_pkg::OFS_STAT, 32'h0, "stat quiet");
   endtask
   // Reset in mid-run clears programmed state
   task automatic t_rst2();
      wr(brc_pkg::OFS_CTRL, 32'h0000_002f);
      wr(brc_pkg::OFS_MASK, 32'h0000_000f);
      fm.pci_abort();
      #1;
      chk(36'(irq), 36'h1, "irq before reset");
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk(36'(irq), 36'h0, "irq after reset");
      chk(36'(pci_rsp), 36'h0, "pci_rsp after reset");
      rchk(brc_pkg::OFS_CTRL, 32'h0, "ctrl after reset");
      rchk(brc_pkg::OFS_MASK, 32'h0, "mask after reset");
      rchk(brc_pkg::OFS_STAT, 32'h0, "stat after reset");
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_ctrl();
      t_abort();
      t_dec();
      t_serr();
      t_par();
      t_rst2();
      complete_run();
   end
   initial begin
      #100000;
      err_count++;
      complete_run();
   end
endmodule
